// ---- card_host_strobe_signals_bench.sv ----
// self-checking bench for the card host strobe port
`timescale 1ns/1ps
module card_host_strobe_signals_bench;
    import chss_pkg::*;
    logic mclk = 0, reset_n = 0, ide_mode_select_n = 1, io_mode_enable = 0;
    logic core_busy = 0, core_irq = 0, ready_wire, write_pulse, write_word;
    logic io_read_strobe_n, io_write_strobe_n, output_enable_n, attr_select_n;
    logic card_enable1_n, card_enable2_n, input_ack_n, ready_irq_out, ready_irq_oe;
    logic common_mem_sel, attr_mem_sel, taskfile_sel, control_block_sel;
    logic [2:0] addr, write_addr;
    logic [1:0] data_oe;
    logic [15:0] data_in, data_out, write_data, core_read_data = 16'hA55A;
    chss_mode_e mode;
    int miscompares = 0, comparisons = 0;
    always #10 mclk = ~mclk;
    chss_host i_host (.mclk(mclk), .ready_irq_out(ready_irq_out), .ready_irq_oe(ready_irq_oe),
        .ready_wire(ready_wire), .io_read_strobe_n(io_read_strobe_n),
        .io_write_strobe_n(io_write_strobe_n), .output_enable_n(output_enable_n),
        .attr_select_n(attr_select_n), .card_enable1_n(card_enable1_n),
        .card_enable2_n(card_enable2_n), .addr(addr), .data_in(data_in));
    chss_strobe_port #(.RESET_CYCLES(3)) i_dut (.mclk(mclk), .reset_n(reset_n),
        .ide_mode_select_n(ide_mode_select_n), .io_mode_enable(io_mode_enable),
        .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
        .output_enable_n(output_enable_n), .attr_select_n(attr_select_n),
        .card_enable1_n(card_enable1_n), .card_enable2_n(card_enable2_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .input_ack_n(input_ack_n),
        .ready_irq_out(ready_irq_out), .ready_irq_oe(ready_irq_oe), .core_busy(core_busy),
        .core_irq(core_irq), .core_read_data(core_read_data), .write_data(write_data),
        .write_addr(write_addr), .write_word(write_word), .write_pulse(write_pulse),
        .common_mem_sel(common_mem_sel), .attr_mem_sel(attr_mem_sel),
        .taskfile_sel(taskfile_sel), .control_block_sel(control_block_sel), .mode(mode));
    // ***********************
    // shared checks and waits
    // ***********************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // bounded wait for the ready pin level, returns cycles taken
    task automatic wait_ready(input logic lvl, output int n);
        for (n = 0; n < 30 && ready_wire !== lvl; n++) begin
            @(posedge mclk);
            #1;
        end
        chk("ready level", lvl, ready_wire);
        if (ready_wire !== lvl)
            results();
    endtask
    task automatic settle();
        repeat (8) @(posedge mclk);
        #1;
    endtask
    // bounded wait for the one-cycle write pulse
    task automatic wait_write();
        int n;
        for (n = 0; n < 20 && write_pulse !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk("write pulse", 1'b1, write_pulse);
        if (write_pulse !== 1'b1)
            results();
    endtask
    // *********
    // scenarios
    // *********
    task automatic t_reset();
        int n;
        @(posedge mclk);
        #1;
        chk("ready in reset", 1'b0, ready_wire);
        @(posedge mclk) reset_n <= 1'b1;
        wait_ready(1'b1, n);
        chk("reset hold", 1'b1, n >= 3);
        @(posedge mclk) core_busy <= 1'b1;
        wait_ready(1'b0, n);
        @(posedge mclk) core_busy <= 1'b0;
        wait_ready(1'b1, n);
        $display("reset and ready done");
    endtask
    task automatic t_io();
        @(posedge mclk) io_mode_enable <= 1'b1;
        settle();
        chk("io mode", CHSS_MODE_IO, mode);
        i_host.start(0, 1'b0, 3'h2, 16'h0000, 2'b00);
        settle();
        chk("input ack", 1'b0, input_ack_n);
        chk("read lanes", 2'b11, data_oe);
        chk("read data", 16'hA55A, data_out);
        i_host.finish();
        settle();
        chk("ack released", 1'b1, input_ack_n);
        chk("lanes released", 2'b00, data_oe);
        i_host.start(1, 1'b0, 3'h5, 16'h3C96, 2'b00);
        settle();
        chk("no early write", 1'b0, write_pulse);
        i_host.finish();
        wait_write();
        chk("write data", 16'h3C96, write_data);
        chk("write addr", 3'h5, write_addr);
        chk("word write", 1'b1, write_word);
        @(posedge mclk) core_irq <= 1'b1;
        settle();
        chk("io irq low", 1'b0, ready_wire);
        @(posedge mclk) core_irq <= 1'b0;
        settle();
        $display("io mode done");
    endtask
    // output enable in memory and io mode with both select levels
    task automatic t_select();
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk) io_mode_enable <= m[1];
            settle();
            i_host.start(2, m[0], 3'h1, 16'h0000, 2'b00);
            settle();
            chk("common sel", !m[1] && m[0], common_mem_sel);
            chk("attr sel", !m[0], attr_mem_sel);
            i_host.finish();
        end
        @(posedge mclk) io_mode_enable <= 1'b0;
        settle();
        i_host.start(0, 1'b0, 3'h0, 16'h0000, 2'b00);
        settle();
        chk("mem ignores read", 3'h4, {input_ack_n, data_oe});
        i_host.finish();
        $display("select done");
    endtask
    task automatic t_ide();
        @(posedge mclk) ide_mode_select_n <= 1'b0;
        settle();
        chk("ide mode", CHSS_MODE_IDE, mode);
        @(posedge mclk) core_irq <= 1'b1;
        settle();
        chk("ide irq high", 1'b1, ready_wire);
        @(posedge mclk) core_irq <= 1'b0;
        settle();
        chk("ide irq low", 1'b0, ready_wire);
        // data register read through the first select
        i_host.start(0, 1'b0, 3'h0, 16'h0000, 2'b01);
        settle();
        chk("task file sel", 2'b10, {taskfile_sel, control_block_sel});
        chk("ide data lanes", 2'b11, data_oe);
        chk("ide read data", 16'hA55A, data_out);
        chk("ide no ack", 1'b1, input_ack_n);
        i_host.finish();
        settle();
        i_host.start(0, 1'b0, 3'h6, 16'h0000, 2'b10);
        settle();
        chk("control sel", 2'b01, {taskfile_sel, control_block_sel});
        chk("ide reg lanes", 2'b01, data_oe);
        i_host.finish();
        settle();
        // byte write to a task file register
        i_host.start(1, 1'b0, 3'h1, 16'h5AC3, 2'b01);
        settle();
        i_host.finish();
        wait_write();
        chk("ide write data", 16'h5AC3, write_data);
        chk("ide write addr", 3'h1, write_addr);
        chk("ide byte write", 1'b0, write_word);
        $display("ide mode done");
    endtask
    initial begin
        t_reset();
        t_io();
        t_select();
        t_ide();
        results();
    end
endmodule

// ---- chss_consts.svh ----
// constants for the card host strobe block
// What this block does
// - in io mode drive input ack low while selected and answering io read
// - drive read data onto bus while io or ide read strobe is low
// - capture write data on rising edge of io or ide write strobe
// - output enable reads common memory and attribute in memory mode, attribute in io
// - ide mode select low enters ide compatible mode
// - attribute select high picks common memory, low picks attribute memory
// - memory mode ready output high when able, low while busy
// - ready stays low after reset until reset processing finishes
// - io mode ready pin is active low interrupt request
// - ide mode ready pin is active high interrupt request
// - ide first select hits task file, second hits control block
// - ide task file uses low byte lanes, data uses full 16 bits
`ifndef CHSS_CONSTS_SVH
`define CHSS_CONSTS_SVH
`define CHSS_RESET_TIME_NS 1000
`define CHSS_CLK_PERIOD_NS 20
`define CHSS_RESET_CYCLES ((`CHSS_RESET_TIME_NS + `CHSS_CLK_PERIOD_NS - 1) / `CHSS_CLK_PERIOD_NS)
`define CHSS_DATA_REG_ADDR 3'h0
`endif

// ---- chss_host.sv ----
// host controller model driving the card strobes
`timescale 1ns/1ps
module chss_host (
    // clock
    input wire logic mclk,
    // ready pin
    // input ack left unconnected at the host
    input wire logic ready_irq_out,
    input wire logic ready_irq_oe,
    output logic ready_wire,
    // host pins
    output logic io_read_strobe_n,
    output logic io_write_strobe_n,
    output logic output_enable_n,
    output logic attr_select_n,
    output logic card_enable1_n,
    output logic card_enable2_n,
    output logic [2:0] addr,
    output logic [15:0] data_in
);
    assign ready_wire = ready_irq_oe ? ready_irq_out : 1'b1;
    initial begin
        {io_read_strobe_n, io_write_strobe_n, output_enable_n} = 3'h7;
        {attr_select_n, card_enable1_n, card_enable2_n} = 3'h7;
        addr = 3'h0;
        data_in = 16'h0000;
    end
    // kind 0 io read, 1 io write, 2 output enable
    task automatic start(input int k, input logic attr, input logic [2:0] a,
                         input logic [15:0] d, input logic [1:0] ce);
        @(posedge mclk);
        addr <= a;
        data_in <= d;
        // select held low in io cycles
        attr_select_n <= (k < 2) ? 1'b0 : attr;
        {card_enable1_n, card_enable2_n} <= ce;
        @(posedge mclk);
        io_read_strobe_n <= (k != 0);
        io_write_strobe_n <= (k != 1);
        output_enable_n <= (k != 2);
    endtask
    task automatic finish();
        @(posedge mclk);
        {io_read_strobe_n, io_write_strobe_n, output_enable_n} <= 3'h7;
        @(posedge mclk);
        // released bus shows a changed value, not the last one
        data_in <= ~data_in;
        addr <= ~addr;
        {attr_select_n, card_enable1_n, card_enable2_n} <= 3'h7;
    endtask
endmodule

// ---- chss_pkg.sv ----
// types for the card host strobe block
package chss_pkg;
    typedef enum logic [2:0] {
        CHSS_MODE_MEM = 3'b001,
        CHSS_MODE_IO = 3'b010,
        CHSS_MODE_IDE = 3'b100
    } chss_mode_e;
    // synchronised host strobe levels
    typedef struct packed {
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic output_enable_n;
        logic attr_select_n;
        logic card_enable1_n;
        logic card_enable2_n;
    } chss_strobes_s;
endpackage

// ---- chss_strobe_port.sv ----
// host strobe, ready and interrupt handling of the card port
`timescale 1ns/1ps
`include "chss_consts.svh"
module chss_strobe_port import chss_pkg::*; #(
    parameter int RESET_CYCLES = `CHSS_RESET_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // host pins
    input wire logic ide_mode_select_n,
    input wire logic io_mode_enable,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic output_enable_n,
    input wire logic attr_select_n,
    input wire logic card_enable1_n,
    input wire logic card_enable2_n,
    input wire logic [2:0] addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [1:0] data_oe,
    output logic input_ack_n,
    output logic ready_irq_out,
    output logic ready_irq_oe,
    // core side
    input wire logic core_busy,
    input wire logic core_irq,
    input wire logic [15:0] core_read_data,
    output logic [15:0] write_data,
    output logic [2:0] write_addr,
    output logic write_word,
    output logic write_pulse,
    output logic common_mem_sel,
    output logic attr_mem_sel,
    output logic taskfile_sel,
    output logic control_block_sel,
    output chss_mode_e mode
);
    // ******************************
    // synchronisers
    // ******************************
    chss_strobes_s raw;
    chss_strobes_s syn;
    chss_strobes_s prev;
    logic [1:0] mode_pins;
    logic [1:0] mode_syn;
    logic [2:0] addr_syn;
    logic [15:0] data_syn;
    assign raw = '{io_read_strobe_n, io_write_strobe_n, output_enable_n,
                   attr_select_n, card_enable1_n, card_enable2_n};
    assign mode_pins = {ide_mode_select_n, io_mode_enable};
    chss_sync #(.WIDTH(6), .INIT(6'h3F)) u_sync_strobes (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(raw),
        .sync_out(syn)
    );
    chss_sync #(.WIDTH(2), .INIT(2'h2)) u_sync_mode (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(mode_pins),
        .sync_out(mode_syn)
    );
    // address and data take the strobes' delay so a write edge sees what stood under it
    // limitation: the host must hold them one mclk past the trailing write edge
    chss_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_addr (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(addr),
        .sync_out(addr_syn)
    );
    chss_sync #(.WIDTH(16), .INIT(16'h0000)) u_sync_data (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(data_in),
        .sync_out(data_syn)
    );

    // ******************************
    // mode and decode
    // ******************************
    chss_mode_e next_mode;
    logic selected;
    logic rd_active;
    logic wr_rise;
    logic oe_active;
    // ide select low picks ide mode
    always_comb begin
        if (!mode_syn[1]) begin
            next_mode = CHSS_MODE_IDE;
        end else if (mode_syn[0]) begin
            next_mode = CHSS_MODE_IO;
        end else begin
            next_mode = CHSS_MODE_MEM;
        end
    end
    assign selected = !syn.card_enable1_n || !syn.card_enable2_n;
    // io strobes only count outside memory mode
    assign rd_active = (mode != CHSS_MODE_MEM) && selected && !syn.io_read_strobe_n;
    assign wr_rise = (mode != CHSS_MODE_MEM) && selected && syn.io_write_strobe_n
                     && !prev.io_write_strobe_n;
    // output enable unused in ide mode
    assign oe_active = (mode != CHSS_MODE_IDE) && selected && !syn.output_enable_n;

    // ******************************
    // datapath and ready
    // ******************************
    logic [$clog2(RESET_CYCLES+1)-1:0] rst_cnt;
    logic [$clog2(RESET_CYCLES+1)-1:0] next_rst_cnt;
    logic [15:0] next_data_out;
    logic [1:0] next_data_oe;
    logic next_input_ack_n;
    logic [15:0] next_write_data;
    logic [2:0] next_write_addr;
    logic next_write_pulse;
    logic next_common;
    logic next_attr;
    logic next_tf;
    logic next_cb;
    logic next_word;
    logic boot_done;
    logic full_word;
    assign boot_done = (rst_cnt == '0);
    assign full_word = !syn.card_enable1_n && !syn.card_enable2_n;
    always_comb begin
        next_rst_cnt = boot_done ? rst_cnt : rst_cnt - 1'b1;
        next_data_out = data_out;
        next_data_oe = 2'h0;
        next_input_ack_n = 1'b1;
        next_write_data = write_data;
        next_write_addr = write_addr;
        next_write_pulse = 1'b0;
        next_word = write_word;
        next_common = (mode != CHSS_MODE_IDE) && oe_active && syn.attr_select_n
                      && (mode == CHSS_MODE_MEM);
        next_attr = (mode != CHSS_MODE_IDE) && oe_active && !syn.attr_select_n;
        // ide chip selects split register sets
        next_tf = (mode == CHSS_MODE_IDE) && !syn.card_enable1_n;
        next_cb = (mode == CHSS_MODE_IDE) && !syn.card_enable2_n;
        // drive read data while strobe low
        if (boot_done && (rd_active || next_common || next_attr)) begin
            next_data_out = core_read_data;
            // task file on low lane, data register full width
            if (mode == CHSS_MODE_IDE) begin
                next_data_oe = (next_tf && addr_syn == `CHSS_DATA_REG_ADDR) ? 2'h3 : 2'h1;
            end else begin
                next_data_oe = full_word ? 2'h3 : (syn.card_enable1_n ? 2'h2 : 2'h1);
            end
        end
        if (boot_done && rd_active && mode == CHSS_MODE_IO) begin
            next_input_ack_n = 1'b0;
        end
        if (boot_done && wr_rise) begin
            next_write_data = data_syn;
            next_write_addr = addr_syn;
            next_write_pulse = 1'b1;
            next_word = (mode == CHSS_MODE_IDE) ? (next_tf && addr_syn == `CHSS_DATA_REG_ADDR)
                        : full_word;
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_cnt <= ($clog2(RESET_CYCLES+1))'(RESET_CYCLES);
            mode <= CHSS_MODE_MEM;
            prev <= 6'h3F;
            data_out <= 16'h0000;
            data_oe <= 2'h0;
            input_ack_n <= 1'b1;
            write_data <= 16'h0000;
            write_pulse <= 1'b0;
            write_word <= 1'b0;
            write_addr <= 3'h0;
            common_mem_sel <= 1'b0;
            attr_mem_sel <= 1'b0;
            taskfile_sel <= 1'b0;
            control_block_sel <= 1'b0;
        end else begin
            rst_cnt <= next_rst_cnt;
            mode <= next_mode;
            prev <= syn;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            input_ack_n <= next_input_ack_n;
            write_data <= next_write_data;
            write_pulse <= next_write_pulse;
            write_word <= next_word;
            write_addr <= next_write_addr;
            common_mem_sel <= next_common;
            attr_mem_sel <= next_attr;
            taskfile_sel <= next_tf;
            control_block_sel <= next_cb;
        end
    end
    // ready pin: mem ready, io irq low, ide irq high; open drain except ide
    always_comb begin
        ready_irq_out = 1'b0;
        ready_irq_oe = 1'b0;
        unique case (mode)
            CHSS_MODE_MEM: ready_irq_oe = !boot_done || core_busy;
            CHSS_MODE_IO: ready_irq_oe = !boot_done || core_irq;
            CHSS_MODE_IDE: begin
                ready_irq_oe = 1'b1;
                ready_irq_out = boot_done && core_irq;
            end
        endcase
    end

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_wr_edge;
        wr_rise && boot_done;
    endsequence
    sequence s_wr_landed;
        write_pulse && write_data == $past(data_syn);
    endsequence
    input_ack_io_a: assert property (!input_ack_n |-> mode == CHSS_MODE_IO)
        else $error("input ack outside io mode");
    read_drive_a: assert property (rd_active && boot_done |=> data_oe != 2'h0)
        else $error("read strobe not answered");
    write_capture_a: assert property (s_wr_edge |=> s_wr_landed)
        else $error("write edge not captured");
    ide_mode_a: assert property (mode_syn[1] == 1'b0 |=> mode == CHSS_MODE_IDE)
        else $error("ide mode not entered");
    boot_busy_a: assert property (!boot_done && mode == CHSS_MODE_MEM |-> ready_irq_oe)
        else $error("ready released during reset processing");
    io_irq_a: assert property (mode == CHSS_MODE_IO && core_irq |-> ready_irq_oe)
        else $error("io interrupt not driven low");
    ide_irq_a: assert property (mode == CHSS_MODE_IDE && boot_done && core_irq
                                |-> ready_irq_out)
        else $error("ide interrupt not high");
    mem_ignore_a: assert property (mode == CHSS_MODE_MEM |=> !write_pulse)
        else $error("io write acted in memory mode");
    attr_decode_a: assert property (common_mem_sel |-> !attr_mem_sel)
        else $error("both memory spaces selected");
endmodule

// ---- chss_sync.sv ----
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module chss_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // async in, filtered out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_out;
    // a change counts only when stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_out[i] = (s2[i] == s3[i]) ? s3[i] : sync_out[i];
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            sync_out <= INIT;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            sync_out <= next_out;
        end
    end
endmodule
